// ==== dtc_timing_ctrl.sv ====
// Top of the clock derivation and external condition input block
`timescale 1ns/1ps
`default_nettype none
// Function
// - A machine cycle lasts two or four crystal ticks as cycle_length_select picks.
// - The divided clock output runs at the crystal rate divided by two to sixteen.
// - instruction_strobe rises each time a new instruction starts.
// - Halt holds the program counter and loop counter still.
// - A high low_power_freeze freezes all internal operation except the lane enable and shared pin outputs.
// - Each edge condition input latches a falling edge, cleared when a branch tests it.
// - Level condition inputs serve as branch conditions or interrupts, the third also low power.
// - The hardware NOP input replaces the fetched instruction with a no-operation.
// - Low and high byte buffer enables are driven separately for each data lane.
// - The third and fourth edge inputs share pins five and six with bus available and transfer acknowledge.
module dtc_timing_ctrl
	import dtc_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int LC_W = 10
) (
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	input  wire logic               cycle_length_select,
	input  wire logic               halt,
	input  wire logic               low_power_freeze,
	input  wire logic               hw_nop,
	input  wire logic [LEVEL_N-1:0] level_condition_inputs,
	input  wire logic               level_as_interrupt,
	input  wire logic [EDGE_N-1:0]  edge_condition_inputs,
	input  wire logic               pin5_host_mode,
	input  wire logic               pin6_host_mode,
	input  wire logic               bus_available_int,
	input  wire logic               transfer_ack_int,
	input  wire logic               div_load,
	input  wire logic [DIV_W-1:0]   div_value,
	input  wire logic               branch_test,
	input  wire logic [2:0]         branch_sel,
	input  wire logic [31:0]        fetched_instr,
	input  wire logic               pc_load,
	input  wire logic [PC_W-1:0]    pc_target,
	input  wire logic               lc_load,
	input  wire logic [LC_W-1:0]    lc_value,
	input  wire logic               bus_write,
	input  wire logic               bus_low_lane,
	input  wire logic               bus_high_lane,
	output logic                    half_rate_clock_out,
	output logic                    programmable_clock_out,
	output logic                    instruction_strobe,
	output logic                    branch_cond,
	output logic [LEVEL_N-1:0]      interrupt_inputs,
	output logic                    low_power_active,
	output logic [31:0]             exec_instr,
	output logic [PC_W-1:0]         pc_out,
	output logic [LC_W-1:0]         lc_out,
	output logic                    low_byte_buffer_enable,
	output logic                    high_byte_buffer_enable,
	output logic                    bus_available_out,
	output logic                    bus_available_oe,
	output logic                    transfer_ack_out,
	output logic                    transfer_ack_oe
);
	dtc_phase_e         phase_reg;
	dtc_phase_e         phase_next;
	logic [DIV_W-1:0]   div_reg;
	logic [EDGE_N-1:0]  edge_prev_reg;
	logic [EDGE_N-1:0]  edge_flag_reg;
	logic [EDGE_N-1:0]  edge_usable;
	logic [EDGE_N-1:0]  edge_fall;
	logic [EDGE_N-1:0]  edge_clear;
	logic               run;
	logic               cycle_end;
	logic               adv;
	logic               div_ok;
	logic               sel_edge;
	logic [1:0]         sel_idx;
	logic               cond_now;
	dtc_lane_s          lane;
	logic               clk_div_q;
	logic               strobe_next;
	logic [PC_W-1:0]    pc_next;
	logic [LC_W-1:0]    lc_next;
	logic [31:0]        exec_next;
	logic [EDGE_N-1:0]  edge_flag_next;
	logic [LEVEL_N-1:0] irq_next;

	// Freeze covers every flop except the lane enable, shared pin and divided clock output flops; the divided clock still stops, by intent, as its divider freezes
	assign run = ce & ~low_power_freeze;

	// Short cycle ends at phase 1, long cycle at phase 3
	assign cycle_end = cycle_length_select ? (phase_reg == DTC_PH3) : (phase_reg == DTC_PH1);
	assign adv       = cycle_end & ~halt;

	always_comb begin
		phase_next = DTC_PH0;
		case (phase_reg)
			DTC_PH0: phase_next = DTC_PH1;
			DTC_PH1: phase_next = cycle_length_select ? DTC_PH2 : DTC_PH0;
			DTC_PH2: phase_next = DTC_PH3;
			DTC_PH3: phase_next = DTC_PH0;
			default: phase_next = DTC_PH0;
		endcase
	end

	// Divisor setting; out-of-range loads are ignored, code zero means sixteen
	assign div_ok = ((div_value >= DIV_MIN) && (div_value <= DIV_MAX))
		|| (div_value == DIV_TOP_CODE);

	// Edge latches; pins lent to host outputs are not sampled
	assign edge_usable = {~pin6_host_mode, ~pin5_host_mode, 2'b11};
	assign edge_fall   = edge_prev_reg & ~edge_condition_inputs & edge_usable;
	assign sel_edge    = branch_sel[2];
	assign sel_idx     = branch_sel[1:0];
	assign edge_clear  = (branch_test && sel_edge) ? (EDGE_N'(1) << sel_idx) : '0;

	// Branch condition select: edge latch or level pin
	assign cond_now = sel_edge ? edge_flag_reg[sel_idx]
		: (sel_idx < 2'(LEVEL_N)) ? level_condition_inputs[sel_idx] & ~level_as_interrupt
		: 1'b0;

	assign lane.low_en  = bus_write & bus_low_lane;
	assign lane.high_en = bus_write & bus_high_lane;

	// Next values kept as named wires so the clocked blocks stay short
	assign strobe_next    = cycle_end ? ~halt
		: (phase_next == DTC_PH1) ? 1'b0
		: instruction_strobe;
	assign pc_next        = pc_load ? pc_target : PC_W'(pc_out + PC_W'(1));
	assign lc_next        = lc_load ? lc_value : lc_out;
	assign exec_next      = hw_nop ? NOP_CODE : fetched_instr;
	// Fresh edge wins over a same-cycle test clear
	assign edge_flag_next = (edge_flag_reg & ~edge_clear) | edge_fall;
	assign irq_next       = level_as_interrupt ? level_condition_inputs : '0;

	// Machine-cycle sequencer; strobe rises at the start of each cycle that follows an unhalted cycle end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg           <= DTC_PH0;
			half_rate_clock_out <= 1'b0;
			instruction_strobe  <= 1'b0;
		end else if (run) begin
			phase_reg           <= phase_next;
			half_rate_clock_out <= ~half_rate_clock_out;
			instruction_strobe  <= strobe_next;
		end
	end

	// Counters move only at an unhalted cycle end, so halt needs no extra gating
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_out     <= '0;
			lc_out     <= '0;
			exec_instr <= NOP_CODE;
		end else if (run && adv) begin
			pc_out     <= pc_next;
			lc_out     <= lc_next;
			exec_instr <= exec_next;
		end
	end

	// Divisor setting; a refused load leaves the old divisor running
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= DIV_RESET;
		end else if (run && div_load && div_ok) begin
			div_reg <= div_value;
		end
	end

	// Edge history and latched falls; history idles high so reset makes no edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			edge_prev_reg <= '1;
			edge_flag_reg <= '0;
		end else if (run) begin
			edge_prev_reg <= edge_condition_inputs;
			edge_flag_reg <= edge_flag_next;
		end
	end

	// Branch condition and level input routing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			branch_cond      <= 1'b0;
			interrupt_inputs <= '0;
			low_power_active <= 1'b0;
		end else if (run) begin
			branch_cond      <= cond_now;
			interrupt_inputs <= irq_next;
			low_power_active <= level_condition_inputs[LOW_POWER_IDX];
		end
	end

	// Lane enables and shared pins stay live so buses settle under freeze
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_byte_buffer_enable  <= 1'b0;
			high_byte_buffer_enable <= 1'b0;
			bus_available_out       <= 1'b0;
			bus_available_oe        <= 1'b0;
			transfer_ack_out        <= 1'b0;
			transfer_ack_oe         <= 1'b0;
			programmable_clock_out  <= 1'b0;
		end else if (ce) begin
			low_byte_buffer_enable  <= lane.low_en;
			high_byte_buffer_enable <= lane.high_en;
			bus_available_out       <= bus_available_int;
			bus_available_oe        <= pin5_host_mode;
			transfer_ack_out        <= transfer_ack_int;
			transfer_ack_oe         <= pin6_host_mode;
			programmable_clock_out  <= clk_div_q;
		end
	end

	dtc_clk_div #(
		.W(DIV_W)
	) dtc_clk_div_i (
		.clk     (clk),
		.rst_b   (rst_b),
		.ce      (run),
		.divisor (div_reg),
		.clk_out (clk_div_q)
	);
endmodule // dtc_timing_ctrl
`default_nettype wire

// ==== dtc_pkg.sv ====
// Package with constants and carrier types for the timing and condition block
package dtc_pkg;
	localparam int          DIV_W         = 4;
	localparam logic [3:0]  DIV_RESET     = 4'h2;
	localparam logic [3:0]  DIV_MIN       = 4'h2;
	localparam logic [3:0]  DIV_MAX       = 4'hF;
	localparam logic [3:0]  DIV_TOP_CODE  = 4'h0; // Stands for divide-by-sixteen
	localparam int          EDGE_N        = 4;
	localparam int          LEVEL_N       = 3;
	localparam int          EDGE_BA_IDX   = 2;
	localparam int          EDGE_ACK_IDX  = 3;
	localparam int          LOW_POWER_IDX = 2;
	localparam logic [1:0]  PH_SHORT_LAST = 2'h1;
	localparam logic [1:0]  PH_LONG_LAST  = 2'h3;
	localparam logic [31:0] NOP_CODE      = 32'h0000_0000;

	typedef enum logic [1:0] {
		DTC_PH0 = 2'b00,
		DTC_PH1 = 2'b01,
		DTC_PH2 = 2'b11,
		DTC_PH3 = 2'b10
	} dtc_phase_e;

	typedef struct packed {
		logic low_en;
		logic high_en;
	} dtc_lane_s;
endpackage

// ==== dtc_clk_div.sv ====
// Programmable divider for the divided clock output
`timescale 1ns/1ps
`default_nettype none
module dtc_clk_div
	import dtc_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic [W-1:0] divisor,
	output logic              clk_out
);
	logic [W-1:0] cnt_reg;
	logic [W:0]   div_full;
	logic [W-1:0] half_lo;
	logic         wrap;
	logic         edge_lo;

	// Code zero reaches one past the field's top value
	assign div_full = (divisor == '0) ? {1'b1, {W{1'b0}}} : {1'b0, divisor};
	// Odd divisors give a low phase one tick longer than high
	assign half_lo  = W'(div_full >> 1);
	assign wrap     = ({1'b0, cnt_reg} >= (div_full - {{W{1'b0}}, 1'b1}));
	assign edge_lo  = (cnt_reg == W'(half_lo - W'(1)));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			clk_out <= 1'b0;
		end else if (ce) begin
			cnt_reg <= wrap ? '0 : W'(cnt_reg + W'(1));
			if (wrap)
				clk_out <= 1'b1;
			else if (edge_lo)
				clk_out <= 1'b0;
		end
	end
endmodule // dtc_clk_div
`default_nettype wire

// ==== dtc_checker.sv ====
// Concurrent checks on the timing and condition block ports
`timescale 1ns/1ps
`default_nettype none
module dtc_checker
	import dtc_pkg::*;
#(
	parameter int PC_W = 16,
	parameter int LC_W = 10
) (
	input wire logic            clk,
	input wire logic            rst_b,
	input wire logic            ce,
	input wire logic            cycle_length_select,
	input wire logic            halt,
	input wire logic            low_power_freeze,
	input wire logic            hw_nop,
	input wire logic            pin5_host_mode,
	input wire logic            pin6_host_mode,
	input wire logic            half_rate_clock_out,
	input wire logic            instruction_strobe,
	input wire logic [31:0]     exec_instr,
	input wire logic [PC_W-1:0] pc_out,
	input wire logic [LC_W-1:0] lc_out,
	input wire logic            bus_available_oe,
	input wire logic            transfer_ack_oe
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Machine cycles run only with nothing stalling them
	wire run2 = ce && !halt && !low_power_freeze && !cycle_length_select;
	wire run4 = ce && !halt && !low_power_freeze && cycle_length_select;
	sequence s_short; $rose(instruction_strobe) && run2 ##1 run2; endsequence
	sequence s_long; $rose(instruction_strobe) && run4 ##1 run4 [*3]; endsequence
	property p_short; s_short |=> $rose(instruction_strobe); endproperty
	a_short: assert property (p_short) else $error("short cycle wrong");
	property p_long; s_long |=> $rose(instruction_strobe); endproperty
	a_long: assert property (p_long) else $error("long cycle wrong");
	property p_nostb; halt |=> !$rose(instruction_strobe); endproperty
	a_nostb: assert property (p_nostb) else $error("strobe under halt");
	property p_half; ce && !low_power_freeze |=> $changed(half_rate_clock_out); endproperty
	a_half: assert property (p_half) else $error("half rate stuck");
	property p_hold; halt |=> $stable(pc_out) && $stable(lc_out); endproperty
	a_hold: assert property (p_hold) else $error("counters moved");
	property p_frz; low_power_freeze |=> $stable(pc_out) && $stable(exec_instr); endproperty
	a_frz: assert property (p_frz) else $error("freeze leaked");
	property p_nop; $past(hw_nop) && $changed(exec_instr) |-> exec_instr == NOP_CODE; endproperty
	a_nop: assert property (p_nop) else $error("nop not forced");
	property p_pin; ce |=> {bus_available_oe, transfer_ack_oe} ==
		$past({pin5_host_mode, pin6_host_mode}); endproperty
	a_pin: assert property (p_pin) else $error("pin mode wrong");
endmodule // dtc_checker
bind dtc_timing_ctrl dtc_checker #(.PC_W(PC_W), .LC_W(LC_W)) dtc_checker_i (.clk, .rst_b, .ce,
	.cycle_length_select, .halt, .low_power_freeze, .hw_nop, .pin5_host_mode, .pin6_host_mode,
	.half_rate_clock_out, .instruction_strobe, .exec_instr, .pc_out, .lc_out,
	.bus_available_oe, .transfer_ack_oe);
`default_nettype wire

// ==== dtc_board.sv ====
// Board model that drives the edge condition pins
`timescale 1ns/1ps
`default_nettype none
module dtc_board
	import dtc_pkg::*;
(
	input  wire logic [EDGE_N-1:0] fall_req,
	input  wire logic              clk,
	output var logic [EDGE_N-1:0]  edge_condition_inputs
);
	// Pins idle high as pulled up, low only while a fall is asked
	initial edge_condition_inputs = 4'hF;
	always @(posedge clk) edge_condition_inputs <= #2 ~fall_req;
endmodule // dtc_board
`default_nettype wire

// ==== dtc_timing_ctrl_tb.sv ====
// Self-checking bench for the timing and condition block
`timescale 1ns/1ps
`default_nettype none
module dtc_timing_ctrl_tb
	import dtc_pkg::*;
;
	logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, cycle_length_select = 1'h0, halt = 1'h0;
	logic low_power_freeze = 1'h0, hw_nop = 1'h0, level_as_interrupt = 1'h0, div_load = 1'h0;
	logic pin5_host_mode = 1'h0, pin6_host_mode = 1'h0, bus_available_int = 1'h0;
	logic transfer_ack_int = 1'h0, branch_test = 1'h0, pc_load = 1'h0, lc_load = 1'h0;
	logic bus_write = 1'h1, bus_low_lane = 1'h0, bus_high_lane = 1'h0;
	logic [2:0] level_condition_inputs = 3'h0, branch_sel = 3'h0;
	logic [3:0] div_value = 4'h0, fall_req = 4'h0;
	logic [31:0] fetched_instr = 32'h0;
	logic [15:0] pc_target = 16'h0;
	logic [9:0] lc_value = 10'h0;
	wire [3:0] edge_condition_inputs;
	wire [31:0] exec_instr;
	wire [15:0] pc_out;
	wire [9:0] lc_out;
	wire [2:0] interrupt_inputs;
	wire half_rate_clock_out, programmable_clock_out, instruction_strobe, branch_cond;
	wire low_power_active, low_byte_buffer_enable, high_byte_buffer_enable;
	wire bus_available_out, bus_available_oe, transfer_ack_out, transfer_ack_oe;
	int error_cnt = 0, n_compared = 0;
	dtc_timing_ctrl dtc_timing_ctrl_i (.*);
	dtc_board dtc_board_i (.*);
	// 20 MHz clock
	initial forever #25 clk = ~clk;
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	// Cycles between two rises of the strobe or the divided clock
	task gap(input logic w, output int g);
		logic p;
		g = 0;
		for (int i = 0; i < 80; i++) begin
			p = w ? programmable_clock_out : instruction_strobe;
			cyc(1);
			if ((w ? programmable_clock_out : instruction_strobe) && !p) begin
				if (g > 0) break;
				g = 1;
			end else if (g > 0) g++;
		end
	endtask
	task bt(input logic [2:0] s, input logic e);
		{branch_sel, branch_test} = {s, 1'h1};
		cyc(1);
		chk("branch", branch_cond, e);
		branch_test = 1'h0;
		cyc(1);
	endtask
	// Reset divisor, three loads and a refused one after the first
	task t_div;
		int g;
		gap(1'h1, g);
		chk("div reset", g, 2);
		for (int i = 0; i < 4; i++) begin
			{div_value, div_load} = {i == 0 ? 4'h5 : i == 1 ? 4'h1 : i == 2 ? 4'hF : 4'h0, 1'h1};
			cyc(1);
			div_load = 1'h0;
			gap(1'h1, g);
			gap(1'h1, g);
			chk("div period", g, i == 3 ? 16 : i == 2 ? 15 : 5);
		end
	endtask
	task t_cyc;
		int g;
		logic [15:0] p;
		for (int m = 0; m < 2; m++) begin
			cycle_length_select = m[0];
			gap(1'h0, g);
			gap(1'h0, g);
			chk("cycle len", g, m ? 4 : 2);
			p = pc_out;
			cyc(g);
			chk("pc step", pc_out, p + 16'h1);
		end
	endtask
	// Halt, freeze and clock enable each stall the counters
	task t_frz;
		logic [15:0] p;
		logic [9:0]  l;
		for (int k = 0; k < 3; k++) begin
			{ce, low_power_freeze, halt} = k == 0 ? 3'h5 : k == 1 ? 3'h6 : 3'h0;
			{pc_target, lc_value, pc_load, lc_load} = {16'h1234, 10'h2AA, k == 0, k == 0};
			p = pc_out;
			l = lc_out;
			cyc(9);
			chk("frozen pc", pc_out, p);
			chk("frozen lc", lc_out, l);
			{ce, low_power_freeze, halt} = 3'h4;
			cyc(4);
			chk("loaded", {pc_out, lc_out}, k == 0 ? {16'h1234, 10'h2AA} : {p + 16'h1, l});
		end
	endtask
	task t_nop;
		fetched_instr = 32'hA5A5_5A5A;
		for (int k = 0; k < 2; k++) begin
			hw_nop = k[0];
			cyc(5);
			chk("exec", exec_instr, k ? NOP_CODE : 32'hA5A5_5A5A);
		end
	endtask
	// Edge latch, shared pins, lanes and level inputs
	task t_io;
		fall_req = 4'h1;
		cyc(2);
		fall_req = 4'h0;
		cyc(4);
		bt(3'h4, 1'h1);
		bt(3'h4, 1'h0);
		{pin5_host_mode, bus_available_int, pin6_host_mode, transfer_ack_int} = 4'hE;
		fall_req = 4'h4;
		cyc(2);
		fall_req = 4'h0;
		cyc(3);
		chk("pins", {bus_available_oe, bus_available_out, transfer_ack_oe, transfer_ack_out}, 4'hE);
		bt(3'h6, 1'h0);
		{bus_low_lane, bus_high_lane, level_as_interrupt, level_condition_inputs} = 6'h29;
		cyc(2);
		chk("lanes", {low_byte_buffer_enable, high_byte_buffer_enable}, 2'h2);
		chk("irq", interrupt_inputs, 3'h1);
		chk("low power", low_power_active, 1'h0);
		{bus_low_lane, bus_high_lane, level_as_interrupt, level_condition_inputs} = 6'h16;
		cyc(2);
		chk("lanes", {low_byte_buffer_enable, high_byte_buffer_enable}, 2'h1);
		chk("low power", low_power_active, 1'h1);
		chk("irq", interrupt_inputs, 3'h0);
		bt(3'h1, 1'h1);
		bt(3'h0, 1'h0);
		bus_write = 1'h0;
		cyc(2);
		chk("lanes", {low_byte_buffer_enable, high_byte_buffer_enable}, 2'h0);
	endtask
	task close_out;
		if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(4);
		rst_b = 1'h1;
		t_div();
		t_cyc();
		t_frz();
		t_nop();
		t_io();
		close_out();
	end
	// Run needs under 300 cycles
	initial begin
		#100us;
		error_cnt++;
		close_out();
	end
endmodule // dtc_timing_ctrl_tb
`default_nettype wire
